/* File: rtl/xbus_peripheral_enable_decode.sv */
// enable register, global lock, emulation override and access routing
module xbus_peripheral_enable_decode (
  // clock and reset
  input  wire logic                               clock,
  input  wire logic                               arst_n,
  // straps and mode
  input  wire logic                               extAccessPin,
  input  wire logic                               emulationMode,
  // register port
  input  wire logic [15:0]                        regAddr,
  input  wire logic [15:0]                        regWdata,
  input  wire logic                               regWrite,
  input  wire logic                               regRead,
  output logic      [15:0]                        regRdata,
  // access routing
  input  wire logic [23:0]                        accAddr,
  output xbus_decode_pkg::target_t                accTarget,
  output logic [xbus_decode_pkg::NUM_EN-1:0]      pinGpio,
  output logic [xbus_decode_pkg::NUM_EN-1:0]      effEnable
);
  logic [15:0] enable_reg, enable_next;  // peripheral enable register
  logic        global_reg, global_next;  // global ext bus enable, sticky
  logic        strap_reg, strap_next;          // access pin caught after reset
  logic        strapDone_reg, strapDone_next;  // strap taken
  logic [15:0] rdata_reg, rdata_next;    // read data, one cycle later
  logic [15:0] sysView;                  // configuration register view

  xbus_enable_if ifc ();

  // emulation shows every bit set to the decoder
  assign ifc.effEnable = emulationMode ? {xbus_decode_pkg::NUM_EN{1'b1}}
                                       : enable_reg[xbus_decode_pkg::NUM_EN-1:0]; // [RQ16]
  assign ifc.globalEn  = global_reg;
  assign ifc.strapLatched = strap_reg;
  assign effEnable     = ifc.effEnable;
  assign regRdata      = rdata_reg;

  always_comb begin
    sysView = 16'h0000;
    sysView[xbus_decode_pkg::SYSCFG_GLOBAL_BIT] = global_reg;
    sysView[xbus_decode_pkg::SYSCFG_STRAP_BIT]  = strap_reg;
    sysView[xbus_decode_pkg::SYSCFG_EMU_BIT]    = emulationMode;
  end

  // register writes and read mux
  always_comb begin
    enable_next = enable_reg;
    global_next = global_reg;
    strap_next     = strap_reg;
    strapDone_next = 1'b1;
    rdata_next  = 16'h0000;
    // strap sampled on the first clock after reset release, never by the reset itself
    if (!strapDone_reg) strap_next = extAccessPin; // [RQ18]
    if (regWrite) begin
      if (regAddr == xbus_decode_pkg::PERIPH_EN_OFFSET) begin
        // once globally enabled the map is frozen; upper bits dropped whatever sent
        if (!global_reg) enable_next = regWdata & xbus_decode_pkg::PERIPH_EN_MASK; // [RQ15] [RQ19] [RQ17]
      end else if (regAddr == xbus_decode_pkg::SYSCFG_OFFSET) begin
        // global enable can be set but not cleared short of reset
        if (regWdata[xbus_decode_pkg::SYSCFG_GLOBAL_BIT]) global_next = 1'b1; // [RQ15]
      end
    end
    if (regRead) begin
      if (regAddr == xbus_decode_pkg::PERIPH_EN_OFFSET) begin
        rdata_next = enable_reg & xbus_decode_pkg::PERIPH_EN_MASK; // [RQ19]
      end else if (regAddr == xbus_decode_pkg::SYSCFG_OFFSET) begin
        rdata_next = sysView;
      end else begin
        rdata_next = 16'h0000; // unmapped reads as zero
      end
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      enable_reg <= xbus_decode_pkg::PERIPH_EN_RESET; // [RQ14]
      global_reg <= 1'b0;
      strap_reg     <= 1'b0;
      strapDone_reg <= 1'b0;
      rdata_reg  <= 16'h0000;
    end else begin
      enable_reg <= enable_next;
      global_reg <= global_next;
      strap_reg     <= strap_next;
      strapDone_reg <= strapDone_next;
      rdata_reg  <= rdata_next;
    end
  end

  // routing
  xbus_addr_decode uDec (
    .en     (ifc.sink),
    .addr   (accAddr),
    .target (accTarget)
  );

  // pin release
  xbus_pin_release uPins (
    .en      (ifc.sink),
    .pinGpio (pinGpio)
  );

  // frozen register ignores writes
  lockHold_a: assert property (@(posedge clock) disable iff (!arst_n) // [RQ15]
    global_reg && regWrite && regAddr == xbus_decode_pkg::PERIPH_EN_OFFSET
    |=> $stable(enable_reg))
    else $error("enable register changed while locked");
  // unlocked write lands masked
  writeLand_a: assert property (@(posedge clock) disable iff (!arst_n) // [RQ19]
    !global_reg && regWrite && regAddr == xbus_decode_pkg::PERIPH_EN_OFFSET
    |=> enable_reg == ($past(regWdata) & xbus_decode_pkg::PERIPH_EN_MASK))
    else $error("enable write not applied");
  upperZero_a: assert property (@(posedge clock) disable iff (!arst_n) // [RQ17]
    enable_reg[15:11] == 5'h00)
    else $error("upper enable bits set");
  emuForce_a: assert property (@(posedge clock) disable iff (!arst_n) // [RQ16]
    emulationMode |-> &ifc.effEnable)
    else $error("emulation did not force enables");
  pinFree_a: assert property (@(posedge clock) disable iff (!arst_n) // [RQ13]
    pinGpio == ~ifc.effEnable)
    else $error("pin release mismatch");
  smallRam_a: assert property (@(posedge clock) disable iff (!arst_n) // [RQ3]
    accAddr >= xbus_decode_pkg::SRAM_LO && accAddr <= xbus_decode_pkg::SRAM_HI
    && !ifc.effEnable[xbus_decode_pkg::BIT_SRAM] |-> accTarget == xbus_decode_pkg::TGT_EXTERNAL)
    else $error("small ram window not external");
  winExt_a: assert property (@(posedge clock) disable iff (!arst_n) // [RQ12]
    accAddr >= xbus_decode_pkg::WIN_LO && accAddr <= xbus_decode_pkg::WIN_HI
    && (ifc.effEnable & 11'h7D3) == 11'h000 |-> accTarget == xbus_decode_pkg::TGT_EXTERNAL)
    else $error("empty window not external");
  seg8Flash_a: assert property (@(posedge clock) disable iff (!arst_n) // [RQ18]
    accAddr[23:16] == xbus_decode_pkg::SEG8 && strap_reg
    |-> accTarget == xbus_decode_pkg::TGT_IFLASH)
    else $error("segment 8 not internal flash");
  resetVal_a: assert property (@(posedge clock) // [RQ14]
    $rose(arst_n) |-> enable_reg == xbus_decode_pkg::PERIPH_EN_RESET)
    else $error("bad enable reset value");
endmodule

/* File: rtl/xbus_decode_pkg.sv */
// constants and types for the extension-bus peripheral enable and address decoder
// Behaviour
// RQ1 - first can enable gates its range, frees pins
// RQ2 - second can enable gates its range, frees pins
// RQ3 - small ram off sends window external
// RQ4 - large ram off; external only if flash off
// RQ5 - flash off; external only if large ram off
// RQ6 - rtc off; external only if window empty
// RQ7 - pwm off; external only if window empty
// RQ8 - uart off; external only if window empty
// RQ9 - sync serial off; external only if empty
// RQ10 - i2c off; external only if window empty
// RQ11 - misc features off; external only if empty
// RQ12 - whole window external when all disabled
// RQ13 - disabled peripheral pins become general purpose
// RQ14 - reset value enables first can, small ram
// RQ15 - register frozen once global enable set
// RQ16 - emulation forces every enable bit on
// RQ17 - software writes zero to upper bits
// RQ18 - segment 8 decode from latched access pin
// RQ19 - enable bits 0..10 in fixed order
package xbus_decode_pkg;
  localparam int ADDR_W = 24;                               // cpu byte address width
  localparam int REG_W  = 16;                               // register width
  localparam int NUM_EN = 11;                               // implemented enable bits
  localparam logic [15:0] PERIPH_EN_OFFSET = 16'hF024;      // enable register address
  localparam logic [15:0] SYSCFG_OFFSET    = 16'hF026;      // global enable / status
  localparam logic [15:0] PERIPH_EN_RESET  = 16'h0005;      // reset value
  localparam logic [15:0] PERIPH_EN_MASK   = 16'h07FF;      // writable bits
  localparam int SYSCFG_GLOBAL_BIT = 0;                     // global ext bus enable
  localparam int SYSCFG_STRAP_BIT  = 1;                     // latched access pin, read only
  localparam int SYSCFG_EMU_BIT    = 2;                     // emulation mode, read only
  // enable bit positions
  localparam int BIT_CAN1  = 0;
  localparam int BIT_CAN2  = 1;
  localparam int BIT_SRAM  = 2;
  localparam int BIT_LRAM  = 3;
  localparam int BIT_RTC   = 4;
  localparam int BIT_FLASH = 5;
  localparam int BIT_PWM   = 6;
  localparam int BIT_UART  = 7;
  localparam int BIT_SSC   = 8;
  localparam int BIT_I2C   = 9;
  localparam int BIT_MISC  = 10;
  // address windows, inclusive bounds
  localparam logic [23:0] SRAM_LO  = 24'h00E000;
  localparam logic [23:0] SRAM_HI  = 24'h00E7FF;
  localparam logic [23:0] WIN_LO   = 24'h00E800;
  localparam logic [23:0] WIN_HI   = 24'h00EFFF;
  localparam logic [23:0] SSC_LO   = 24'h00E800;
  localparam logic [23:0] UART_LO  = 24'h00E900;
  localparam logic [23:0] I2C_LO   = 24'h00EA00;
  localparam logic [23:0] MISC_LO  = 24'h00EB00;
  localparam logic [23:0] PWM_LO   = 24'h00EC00;
  localparam logic [23:0] RTC_LO   = 24'h00ED00;
  localparam logic [23:0] SLOT_SZ  = 24'h000100;            // 256-byte slot size
  localparam logic [23:0] CAN_LO   = 24'h00EE00;            // can1 / can2 upper slots
  localparam logic [23:0] FLASH_LO = 24'h090000;
  localparam logic [23:0] FLASH_HI = 24'h0EFFFF;
  localparam logic [23:0] LRAM_LO  = 24'h0F0000;
  localparam logic [23:0] LRAM_HI  = 24'h0FFFFF;
  localparam logic [7:0]  SEG8     = 8'h08;
  // routing target of an access
  typedef enum logic [3:0] {
    TGT_NONE, TGT_EXTERNAL, TGT_CAN1, TGT_CAN2, TGT_SRAM, TGT_LRAM, TGT_RTC, TGT_FLASH,
    TGT_PWM, TGT_UART, TGT_SSC, TGT_I2C, TGT_MISC, TGT_IFLASH, TGT_RESERVED
  } target_t;
endpackage

/* File: rtl/xbus_enable_if.sv */
// enable vector carried from the register block to the decoder
interface xbus_enable_if;
  logic [xbus_decode_pkg::NUM_EN-1:0] effEnable; // enables after emulation override
  logic                               globalEn;  // global ext bus enable
  logic                               strapLatched; // access pin caught on the first clock after reset release
  modport source (output effEnable, output globalEn, output strapLatched);
  modport sink   (input effEnable, input globalEn, input strapLatched);
endinterface

/* File: rtl/xbus_addr_decode.sv */
// address decoder routing each access to an on-chip module or external memory
module xbus_addr_decode (
  // enables
  xbus_enable_if.sink              en,
  // access
  input  wire logic [23:0]         addr,
  output xbus_decode_pkg::target_t target
);
  logic [xbus_decode_pkg::NUM_EN-1:0] e;     // shorthand
  logic                               winAny; // any shared-window module on
  logic [23:0]                        slotLo; // start of 256-byte slot

  assign e      = en.effEnable;
  assign winAny = e[xbus_decode_pkg::BIT_CAN1] | e[xbus_decode_pkg::BIT_CAN2]
                | e[xbus_decode_pkg::BIT_RTC]  | e[xbus_decode_pkg::BIT_PWM]
                | e[xbus_decode_pkg::BIT_UART] | e[xbus_decode_pkg::BIT_SSC]
                | e[xbus_decode_pkg::BIT_I2C]  | e[xbus_decode_pkg::BIT_MISC];
  assign slotLo = {addr[23:8], 8'h00};

  // a disabled module inside a live window is blocked, not sent out
  always_comb begin
    target = xbus_decode_pkg::TGT_NONE;
    if (addr[23:16] == xbus_decode_pkg::SEG8) begin
      if (en.strapLatched) begin
        target = xbus_decode_pkg::TGT_IFLASH; // [RQ18]
      end else if (!en.globalEn || !(e[xbus_decode_pkg::BIT_LRAM]
                                     | e[xbus_decode_pkg::BIT_FLASH])) begin
        target = xbus_decode_pkg::TGT_EXTERNAL; // [RQ18]
      end else begin
        target = xbus_decode_pkg::TGT_RESERVED; // [RQ18]
      end
    end else if (addr >= xbus_decode_pkg::SRAM_LO && addr <= xbus_decode_pkg::SRAM_HI) begin
      target = e[xbus_decode_pkg::BIT_SRAM] ? xbus_decode_pkg::TGT_SRAM
                                            : xbus_decode_pkg::TGT_EXTERNAL; // [RQ3]
    end else if (addr >= xbus_decode_pkg::WIN_LO && addr <= xbus_decode_pkg::WIN_HI) begin
      if (!winAny) begin
        target = xbus_decode_pkg::TGT_EXTERNAL; // [RQ12]
      end else if (slotLo == xbus_decode_pkg::SSC_LO) begin
        if (e[xbus_decode_pkg::BIT_SSC]) target = xbus_decode_pkg::TGT_SSC; // [RQ9]
      end else if (slotLo == xbus_decode_pkg::UART_LO) begin
        if (e[xbus_decode_pkg::BIT_UART]) target = xbus_decode_pkg::TGT_UART; // [RQ8]
      end else if (slotLo == xbus_decode_pkg::I2C_LO) begin
        if (e[xbus_decode_pkg::BIT_I2C]) target = xbus_decode_pkg::TGT_I2C; // [RQ10]
      end else if (slotLo == xbus_decode_pkg::MISC_LO) begin
        if (e[xbus_decode_pkg::BIT_MISC]) target = xbus_decode_pkg::TGT_MISC; // [RQ11]
      end else if (slotLo == xbus_decode_pkg::PWM_LO) begin
        if (e[xbus_decode_pkg::BIT_PWM]) target = xbus_decode_pkg::TGT_PWM; // [RQ7]
      end else if (slotLo == xbus_decode_pkg::RTC_LO) begin
        if (e[xbus_decode_pkg::BIT_RTC]) target = xbus_decode_pkg::TGT_RTC; // [RQ6]
      end else if (slotLo == xbus_decode_pkg::CAN_LO) begin
        if (e[xbus_decode_pkg::BIT_CAN1]) target = xbus_decode_pkg::TGT_CAN1; // [RQ1]
      end else begin
        if (e[xbus_decode_pkg::BIT_CAN2]) target = xbus_decode_pkg::TGT_CAN2; // [RQ2]
      end
    end else if (addr >= xbus_decode_pkg::FLASH_LO && addr <= xbus_decode_pkg::FLASH_HI) begin
      if (e[xbus_decode_pkg::BIT_FLASH]) target = xbus_decode_pkg::TGT_FLASH; // [RQ5]
      else if (!e[xbus_decode_pkg::BIT_LRAM]) target = xbus_decode_pkg::TGT_EXTERNAL; // [RQ5]
    end else if (addr >= xbus_decode_pkg::LRAM_LO && addr <= xbus_decode_pkg::LRAM_HI) begin
      if (e[xbus_decode_pkg::BIT_LRAM]) target = xbus_decode_pkg::TGT_LRAM; // [RQ4]
      else if (!e[xbus_decode_pkg::BIT_FLASH]) target = xbus_decode_pkg::TGT_EXTERNAL; // [RQ4]
    end else begin
      target = xbus_decode_pkg::TGT_EXTERNAL;
    end
  end
endmodule

/* File: rtl/xbus_pin_release.sv */
// per-peripheral pin ownership: disabled modules hand pins to general-purpose io
module xbus_pin_release (
  // enables
  xbus_enable_if.sink                      en,
  // pin ownership
  output logic [xbus_decode_pkg::NUM_EN-1:0] pinGpio
);
  // one bit per module; memories have no pins but share the loop for uniformity
  genvar i;
  generate
    for (i = 0; i < xbus_decode_pkg::NUM_EN; i++) begin : gRel
      assign pinGpio[i] = ~en.effEnable[i]; // [RQ13]
    end
  endgenerate
endmodule

/* File: verification/xbus_periph_model.sv */
// far-side model: external memory interface taking the accesses routed to it
module xbus_periph_model (
  // routing from the block
  input  wire xbus_decode_pkg::target_t accTarget,
  // answer
  output logic                          extCycle
);
  timeunit 1ns;
  timeprecision 1ps;
  // external memory starts a cycle only for accesses handed out by the decoder
  assign extCycle = (accTarget == xbus_decode_pkg::TGT_EXTERNAL);
endmodule

/* File: verification/xbus_peripheral_enable_decode_tb.sv */
// self-checking bench for the peripheral enable register and access decoder
module xbus_peripheral_enable_decode_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic                     clock = 1'b0;
  logic                     arst_n = 1'b0;
  logic                     extAccessPin = 1'b0;
  logic                     emulationMode = 1'b0;
  logic                     regWrite = 1'b0;
  logic                     regRead = 1'b0;
  logic [15:0]              regAddr = 16'h0000;
  logic [15:0]              regWdata = 16'h0000;
  logic [15:0]              regRdata;
  logic [23:0]              accAddr = 24'h000000;
  xbus_decode_pkg::target_t accTarget;
  logic [10:0]              pinGpio;
  logic [10:0]              effEnable;
  logic                     extCycle;
  int                       errors = 0;
  int                       n_compared = 0;
  // probe address and owner of each enable bit, in bit order
  logic [23:0] bitAddr [11] = '{24'h00EE00, 24'h00EF00, 24'h00E000, 24'h0F0000, 24'h00ED00,
    24'h090000, 24'h00EC00, 24'h00E900, 24'h00E800, 24'h00EA00, 24'h00EB00};
  xbus_decode_pkg::target_t bitTgt [11] = '{xbus_decode_pkg::TGT_CAN1,
    xbus_decode_pkg::TGT_CAN2, xbus_decode_pkg::TGT_SRAM, xbus_decode_pkg::TGT_LRAM,
    xbus_decode_pkg::TGT_RTC, xbus_decode_pkg::TGT_FLASH, xbus_decode_pkg::TGT_PWM,
    xbus_decode_pkg::TGT_UART, xbus_decode_pkg::TGT_SSC, xbus_decode_pkg::TGT_I2C,
    xbus_decode_pkg::TGT_MISC};

  always #2 clock = ~clock;

  xbus_peripheral_enable_decode uut (.clock(clock), .arst_n(arst_n),
    .extAccessPin(extAccessPin), .emulationMode(emulationMode), .regAddr(regAddr),
    .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
    .accAddr(accAddr), .accTarget(accTarget), .pinGpio(pinGpio), .effEnable(effEnable));
  xbus_periph_model partner (.accTarget(accTarget), .extCycle(extCycle));

  task automatic stop_test();
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // compare of register-sized values
  task automatic cmpV(string what, logic [15:0] exp, logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // compare of routing results
  task automatic cmpT(string what, xbus_decode_pkg::target_t exp,
                      xbus_decode_pkg::target_t got);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %s expected %0d seen %0d", what, exp, got);
    end
  endtask
  // reset with the strap held; strap is caught on the first edge after release
  task automatic doReset(logic pin);
    @(posedge clock);
    arst_n <= 1'b0;
    extAccessPin <= pin;
    repeat (3) @(posedge clock);
    arst_n <= 1'b1;
    repeat (2) @(posedge clock);
  endtask
  task automatic wr(logic [15:0] a, logic [15:0] d);
    @(posedge clock);
    regAddr <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge clock);
    regWrite <= 1'b0;
  endtask
  // data stands only in the cycle after the strobe, then returns to zero
  task automatic rd(logic [15:0] a, logic [15:0] exp);
    @(posedge clock);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clock);
    regRead <= 1'b0;
    #1;
    cmpV("rdata", exp, regRdata);
    @(posedge clock);
    #1;
    cmpV("rdata idle", 16'h0000, regRdata);
  endtask
  task automatic chkT(logic [23:0] a, xbus_decode_pkg::target_t exp);
    @(posedge clock);
    accAddr <= a;
    #1;
    cmpT("target", exp, accTarget);
  endtask
  // routing of a disabled bit j when only bit i is on; the window is live if i sits in it
  function automatic xbus_decode_pkg::target_t offTgt(int i, int j);
    bit wi;
    bit wj;
    wi = !(i inside {2, 3, 5});
    wj = !(j inside {2, 3, 5});
    if ((wi && wj) || (i + j == 8 && (i == 3 || i == 5)))
      return xbus_decode_pkg::TGT_NONE;
    return xbus_decode_pkg::TGT_EXTERNAL;
  endfunction

  // defaults after reset, window boundary, unmapped read
  task automatic t_reset();
    doReset(1'b0);
    rd(16'hF024, 16'h0005);
    cmpV("gpio", 16'h07FA, {5'h00, pinGpio});
    chkT(24'h00E7FF, xbus_decode_pkg::TGT_SRAM);
    chkT(24'h00EE00, xbus_decode_pkg::TGT_CAN1);
    chkT(24'h00EF00, xbus_decode_pkg::TGT_NONE);
    chkT(24'h080000, xbus_decode_pkg::TGT_EXTERNAL);
    rd(16'hF000, 16'h0000);
  endtask
  // everything off: the whole window and all three memories go out
  task automatic t_allOff();
    wr(16'hF024, 16'h0000);
    for (int k = 0; k < 8; k++) begin
      chkT(24'h00E800 + 24'(k) * 24'h000100, xbus_decode_pkg::TGT_EXTERNAL);
    end
    cmpV("ext cycle", 16'h0001, {15'h0000, extCycle});
    chkT(24'h00E000, xbus_decode_pkg::TGT_EXTERNAL);
    chkT(24'h0FFFFF, xbus_decode_pkg::TGT_EXTERNAL);
    chkT(24'h0EFFFF, xbus_decode_pkg::TGT_EXTERNAL);
  endtask
  // one bit at a time, every probe address checked
  task automatic t_single();
    for (int i = 0; i < 11; i++) begin
      wr(16'hF024, 16'h0001 << i);
      rd(16'hF024, 16'h0001 << i);
      cmpV("gpio", ~(16'h0001 << i) & 16'h07FF, {5'h00, pinGpio});
      for (int j = 0; j < 11; j++) begin
        chkT(bitAddr[j], (i == j) ? bitTgt[j] : offTgt(i, j));
      end
    end
    wr(16'hF024, 16'h07FF);
    rd(16'hF024, 16'h07FF);
  endtask
  // emulation forces all enables on, register itself untouched
  task automatic t_emul();
    wr(16'hF024, 16'h0000);
    @(posedge clock);
    emulationMode <= 1'b1;
    chkT(24'h00EF00, xbus_decode_pkg::TGT_CAN2);
    cmpV("eff enable", 16'h07FF, {5'h00, effEnable});
    cmpV("gpio emu", 16'h0000, {5'h00, pinGpio});
    rd(16'hF024, 16'h0000);
    @(posedge clock);
    emulationMode <= 1'b0;
  endtask
  // global lock and segment 8 mapping
  task automatic t_lock();
    doReset(1'b0);
    wr(16'hF024, 16'h0008);
    wr(16'hF026, 16'h0001);
    chkT(24'h080000, xbus_decode_pkg::TGT_RESERVED);
    wr(16'hF024, 16'h0000);
    rd(16'hF024, 16'h0008);
    rd(16'hF026, 16'h0001);
    doReset(1'b0);
    wr(16'hF024, 16'h0000);
    wr(16'hF026, 16'h0001);
    chkT(24'h08FFFF, xbus_decode_pkg::TGT_EXTERNAL);
    doReset(1'b1);
    chkT(24'h080000, xbus_decode_pkg::TGT_IFLASH);
    rd(16'hF026, 16'h0002);
  endtask

  // watchdog: fires after 5000 cycles; the whole run needs well under that
  initial begin
    #20000;
    errors++;
    stop_test();
  end
  // main sequence
  initial begin
    t_reset();
    t_allOff();
    t_single();
    t_emul();
    t_lock();
    stop_test();
  end
endmodule
